// file: logic/pstore_pkg.sv
/*
  Shared constants for the per-port parameter storage and indexed-service status block.
  Assumes a single 100 MHz core clock and a plain strobed register port.
*/
package pstore_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_STATUS = 3;
  // Storage setting encodings
  localparam logic [7:0] STORE_NONE = 8'h00;
  localparam logic [7:0] STORE_UP = 8'h81;
  localparam logic [7:0] STORE_DOWN = 8'h82;
  localparam logic [7:0] STORE_BOTH = 8'h83;
  localparam int STORE_UP_BIT = 0;
  localparam int STORE_DOWN_BIT = 1;
  // Validation type encodings
  localparam logic [7:0] VALID_NONE = 8'h00;
  localparam logic [7:0] VALID_IDENT = 8'h02;
  // Status record encodings
  localparam logic [7:0] REQ_WRITE = 8'h02;
  localparam logic [7:0] REQ_READ = 8'h03;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_ERR = 8'h01;
  // Upload-flag request written by an operator to the device
  localparam logic [7:0] UPFLAG_VALUE = 8'h05;
  localparam logic [15:0] UPFLAG_INDEX = 16'h0002;
  localparam logic [7:0] REV_MIN = 8'h11;
  // Register map: offset = port*0x40 + field offset
  localparam logic [7:0] PORT_STRIDE = 8'h40;
  localparam logic [5:0] OFS_STORE = 6'h00;
  localparam logic [5:0] OFS_VALID = 6'h04;
  localparam logic [5:0] OFS_PSTAT = 6'h08;
  localparam logic [5:0] OFS_IDENT_VID = 6'h0c;
  localparam logic [5:0] OFS_IDENT_DID = 6'h10;
  localparam logic [5:0] OFS_STAT0 = 6'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hf0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hf4;
  localparam logic [7:0] RST_STORE = 8'h00;
  localparam logic [7:0] RST_VALID = 8'h00;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
endpackage : pstore_pkg

// file: logic/pstore_ports.sv
/*
  Parameter-server decisions and indexed-service status records for every master port.
  Assumes a register master with one-cycle strobes and a port engine that reports device
  identity, upload flag, data mismatch and service results as same-clock signals.
*/
// Decided for this implementation: the address-and-strobe port and the register offsets.
// How it works
// R1: Per-port storage byte selects up/down/both
// R2: No-storage setting disables and erases record
// R3: Upload on device flag or empty record
// R4: Download when data differs, no flag
// R5: Keep vendor/device id with uploaded record
// R6: Validate identity at start-up; mismatch blocks
// R7: Device must be revision 1.1 or later
// R8: Operator sets upload flag via index 2
// R9: Newest result enters first status record
// R10: Record bytes: type, result, error, additional
// R11: Single read returns stored record bytes
// R12: Transfers run as acknowledged service exchanges
// R13: Validation type none or identical check
// R14: All state kept separately per port; the interrupt status and mask registers and o_irq are shared by all ports
`timescale 1ns/1ps
`default_nettype none
module pstore_ports
  import pstore_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Async reset, high
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic [PORTS-1:0] i_dev_start, // Device start-up pulse per port
  input wire logic [PORTS*16-1:0] i_dev_vid, // Device vendor id
  input wire logic [PORTS*24-1:0] i_dev_did, // Device device id
  input wire logic [PORTS-1:0] i_dev_sn_ok, // Serial number matches setting
  input wire logic [PORTS*8-1:0] i_dev_rev, // Device protocol revision
  input wire logic [PORTS-1:0] i_dev_upflag, // Device upload flag level
  input wire logic [PORTS-1:0] i_data_diff, // Stored data differs from device
  input wire logic [PORTS-1:0] i_xfer_ack, // Service exchange acknowledged
  input wire logic [PORTS-1:0] i_isdu_done, // Service result pulse
  input wire logic [PORTS-1:0] i_isdu_write, // Result was a write
  input wire logic [PORTS-1:0] i_isdu_err, // Result was an error
  input wire logic [PORTS*16-1:0] i_isdu_code, // Error and additional code
  output logic [PORTS-1:0] o_up_req, // Start upload exchange
  output logic [PORTS-1:0] o_down_req, // Start download exchange
  output logic [PORTS-1:0] o_valid_fail, // Identity check failed
  output logic o_irq // Interrupt, level
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_UP = 4'b0010,
    S_DOWN = 4'b0100,
    S_BLOCK = 4'b1000
  } ps_state_t;

  logic [7:0] store_reg [PORTS];
  logic [7:0] valid_reg [PORTS];
  logic [15:0] vid_reg [PORTS];
  logic [23:0] did_reg [PORTS];
  logic [PORTS-1:0] have_reg;
  ps_state_t st_reg [PORTS];
  logic [31:0] irq_stat_reg;
  logic [31:0] irq_mask_reg;
  logic [31:0] rec_out [PORTS];
  logic [31:0] rdata_next;
  logic [PORTS*4-1:0] evt;
  logic [PORTS-1:0] fail_seen_reg;

  if (PORTS < 1 || PORTS > 4) begin : g_bad_ports
    $error("pstore_ports: PORTS must be 1..4 for this map");
  end

  function automatic logic hit(input logic [7:0] a, input int p, input logic [5:0] ofs);
    hit = (a == 8'((p * 64) + int'(ofs)));
  endfunction : hit

  function automatic logic storage_ok(input logic [7:0] rev);
    storage_ok = (rev >= REV_MIN); // [R7]
  endfunction : storage_ok

  // Configuration registers
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < PORTS; p++) begin
        store_reg[p] <= RST_STORE;
        valid_reg[p] <= RST_VALID;
      end
    end else if (i_wr) begin
      for (int p = 0; p < PORTS; p++) begin
        if (hit(i_addr, p, OFS_STORE)) store_reg[p] <= i_wdata[7:0]; // [R1] [R14]
        if (hit(i_addr, p, OFS_VALID)) valid_reg[p] <= i_wdata[7:0]; // [R13]
      end
    end
  end

  // Parameter server per port
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < PORTS; p++) begin
        st_reg[p] <= S_IDLE;
        vid_reg[p] <= 16'h0000;
        did_reg[p] <= 24'h000000;
      end
      have_reg <= '0;
      o_up_req <= '0;
      o_down_req <= '0;
      o_valid_fail <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        logic up_en;
        logic dn_en;
        logic id_match;
        up_en = store_reg[p][7] && store_reg[p][STORE_UP_BIT];
        dn_en = store_reg[p][7] && store_reg[p][STORE_DOWN_BIT];
        // Stored identity is checked once a record exists; the configured check applies in either case
        id_match = (i_dev_vid[p*16 +: 16] == vid_reg[p]) &&
                   (i_dev_did[p*24 +: 24] == did_reg[p]);
        if (store_reg[p] == STORE_NONE) begin
          have_reg[p] <= 1'b0; // [R2]
          vid_reg[p] <= 16'h0000; // [R2]
          did_reg[p] <= 24'h000000;
          st_reg[p] <= S_IDLE;
          o_up_req[p] <= 1'b0;
          o_down_req[p] <= 1'b0;
          o_valid_fail[p] <= 1'b0;
        end else begin
          case (st_reg[p])
            S_IDLE: begin
              if (i_dev_start[p]) begin
                if (!storage_ok(i_dev_rev[p*8 +: 8])) begin
                  st_reg[p] <= S_IDLE; // [R7]
                end else if ((have_reg[p] && !id_match) ||
                    (valid_reg[p] == VALID_IDENT && !i_dev_sn_ok[p])) begin
                  st_reg[p] <= S_BLOCK; // [R6] [R13]
                  o_valid_fail[p] <= 1'b1;
                end else if (up_en && (i_dev_upflag[p] || !have_reg[p])) begin
                  st_reg[p] <= S_UP; // [R3] [R8]
                  o_up_req[p] <= 1'b1; // [R12]
                end else if (dn_en && have_reg[p] && i_data_diff[p] &&
                    !i_dev_upflag[p]) begin
                  st_reg[p] <= S_DOWN; // [R4]
                  o_down_req[p] <= 1'b1; // [R12]
                end
              end
            end
            S_UP: begin
              if (i_xfer_ack[p]) begin
                o_up_req[p] <= 1'b0;
                have_reg[p] <= 1'b1;
                vid_reg[p] <= i_dev_vid[p*16 +: 16]; // [R5]
                did_reg[p] <= i_dev_did[p*24 +: 24]; // [R5]
                st_reg[p] <= S_IDLE;
              end
            end
            S_DOWN: begin
              if (i_xfer_ack[p]) begin
                o_down_req[p] <= 1'b0;
                st_reg[p] <= S_IDLE;
              end
            end
            S_BLOCK: begin
              // Held until the record is erased by the no-storage setting
              o_valid_fail[p] <= 1'b1; // [R6]
            end
            default: st_reg[p] <= S_IDLE;
          endcase
        end
      end
    end
  end

  // Status record rings, one per port
  for (genvar g = 0; g < PORTS; g++) begin : g_ring
    logic [1:0] sel;
    assign sel = 2'((int'(i_addr[5:0]) - int'(OFS_STAT0)) >> 2);
    status_ring u_ring (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_done(i_isdu_done[g]), // [R14]
      .i_rec({i_isdu_code[g*16+8 +: 8], i_isdu_code[g*16 +: 8],
              (i_isdu_err[g] ? RES_ERR : RES_OK),
              (i_isdu_write[g] ? REQ_WRITE : REQ_READ)}), // [R10]
      .i_sel(sel),
      .o_rec(rec_out[g])
    );
    assign evt[g*4 +: 4] = {i_isdu_done[g] && i_isdu_err[g], i_isdu_done[g],
                            o_valid_fail[g] && !fail_seen_reg[g],
                            i_xfer_ack[g] && (st_reg[g] == S_UP || st_reg[g] == S_DOWN)};
  end

  // Validation-fail event fires once per block entry, not on every held cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) fail_seen_reg <= '0;
    else fail_seen_reg <= o_valid_fail;
  end

  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_reg <= 32'h0000_0000;
      irq_mask_reg <= RST_MASK;
      o_irq <= 1'b0;
    end else begin
      logic [31:0] clr;
      clr = (i_wr && i_addr == OFS_IRQ_STAT) ? i_wdata : 32'h0000_0000;
      irq_stat_reg <= (irq_stat_reg & ~clr) | 32'(evt);
      if (i_wr && i_addr == OFS_IRQ_MASK) irq_mask_reg <= i_wdata;
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_addr == OFS_IRQ_STAT) rdata_next = irq_stat_reg;
    if (i_addr == OFS_IRQ_MASK) rdata_next = irq_mask_reg;
    for (int p = 0; p < PORTS; p++) begin
      if (hit(i_addr, p, OFS_STORE)) rdata_next = {24'h0, store_reg[p]};
      if (hit(i_addr, p, OFS_VALID)) rdata_next = {24'h0, valid_reg[p]};
      if (hit(i_addr, p, OFS_PSTAT)) rdata_next = {27'h0, have_reg[p], 4'(st_reg[p])};
      if (hit(i_addr, p, OFS_IDENT_VID)) rdata_next = {16'h0, vid_reg[p]};
      if (hit(i_addr, p, OFS_IDENT_DID)) rdata_next = {8'h0, did_reg[p]};
      for (int k = 0; k < NUM_STATUS; k++) begin
        if (hit(i_addr, p, 6'(int'(OFS_STAT0) + 4 * k))) rdata_next = rec_out[p]; // [R11]
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) o_rdata <= 32'h0000_0000;
    else if (i_rd) o_rdata <= rdata_next; // [R11]
    else o_rdata <= 32'h0000_0000;
  end

  property p_none_erases;
    @(posedge i_core_clk) disable iff (i_rst)
      (store_reg[0] == STORE_NONE) |=> !have_reg[0] && !o_up_req[0];
  endproperty
  a_none_erases: assert property (p_none_erases) else $error("record kept under no storage"); // [R2]

  property p_upload_start;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_reg[0] == S_IDLE && store_reg[0] == STORE_UP && i_dev_start[0] &&
       storage_ok(i_dev_rev[7:0]) && !have_reg[0] && valid_reg[0] == VALID_NONE)
      |=> o_up_req[0];
  endproperty
  a_upload_start: assert property (p_upload_start) else $error("upload not started"); // [R3]

  property p_down_needs_noflag;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_down_req[0]) |-> !$past(i_dev_upflag[0]) && $past(i_data_diff[0]);
  endproperty
  a_down_needs_noflag: assert property (p_down_needs_noflag) else $error("bad download"); // [R4]

  property p_id_kept;
    @(posedge i_core_clk) disable iff (i_rst)
      (st_reg[0] == S_UP && i_xfer_ack[0] && store_reg[0] != STORE_NONE)
      |=> vid_reg[0] == $past(i_dev_vid[15:0]) && have_reg[0];
  endproperty
  a_id_kept: assert property (p_id_kept) else $error("identity not kept"); // [R5]

  property p_mismatch_blocks;
    @(posedge i_core_clk) disable iff (i_rst)
      o_valid_fail[0] && store_reg[0] != STORE_NONE |-> !o_up_req[0] && !o_down_req[0];
  endproperty
  a_mismatch_blocks: assert property (p_mismatch_blocks) else $error("blocked port moved"); // [R6]

  property p_old_rev;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_dev_start[0] && st_reg[0] == S_IDLE && !storage_ok(i_dev_rev[7:0]))
      |=> !$rose(o_up_req[0]) && !$rose(o_down_req[0]);
  endproperty
  a_old_rev: assert property (p_old_rev) else $error("old device served"); // [R7]

  property p_read_data;
    @(posedge i_core_clk) disable iff (i_rst)
      !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong"); // [R11]

  property p_irq;
    @(posedge i_core_clk) disable iff (i_rst)
      (irq_stat_reg & irq_mask_reg) != 32'h0000_0000 |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong"); // [R9]

  property p_result_flag;
    @(posedge i_core_clk) disable iff (i_rst)
      i_isdu_done[PORTS-1] |=> irq_stat_reg[4 * PORTS - 2];
  endproperty
  a_result_flag: assert property (p_result_flag) else $error("result flag lost"); // [R9]

  property p_port_isolated;
    @(posedge i_core_clk) disable iff (i_rst)
      !i_dev_start[0] && !i_xfer_ack[0] && $stable(store_reg[0]) |=> $stable(st_reg[0]);
  endproperty
  a_port_isolated: assert property (p_port_isolated) else $error("port state moved"); // [R14]

  c_upload: cover property (@(posedge i_core_clk) $fell(o_up_req[0]));
  c_download: cover property (@(posedge i_core_clk) $fell(o_down_req[0]));
  c_block: cover property (@(posedge i_core_clk) $rose(o_valid_fail[0]));
  c_result: cover property (@(posedge i_core_clk) i_isdu_done[PORTS-1] && i_isdu_err[PORTS-1]);
endmodule : pstore_ports
`default_nettype wire

// file: logic/status_ring.sv
/*
  Per-port ring of indexed-service result records, newest first.
  Assumes results arrive as one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module status_ring
  import pstore_pkg::*;
#(
  parameter int DEPTH = NUM_STATUS
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_done, // Result pulse
  input wire logic [31:0] i_rec, // New record, byte 0 in bits 7:0
  input wire logic [1:0] i_sel, // Record to read
  output logic [31:0] o_rec // Selected record
);
  logic [31:0] rec_reg [DEPTH];

  if (DEPTH < 1 || DEPTH > 4) begin : g_bad_depth
    $error("status_ring: DEPTH must be 1..4");
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) rec_reg[i] <= 32'h0000_0000;
    end else if (i_done) begin
      rec_reg[0] <= i_rec; // [R9]
      for (int i = 1; i < DEPTH; i++) rec_reg[i] <= rec_reg[i-1]; // [R9]
    end
  end

  always_comb begin
    o_rec = 32'h0000_0000;
    if (32'(i_sel) < DEPTH) o_rec = rec_reg[i_sel]; // [R11]
  end
endmodule : status_ring
`default_nettype wire

// file: verification/dev_model.sv
/*
  Behavioural model of the IO-Link devices attached to each master port.
  Assumes the bench sets identity, revision and data-change levels per port.
*/
`timescale 1ns/1ps
`default_nettype none
module dev_model
  import pstore_pkg::*;
#(
  parameter int P = 3,
  parameter int DELAY = 2,
  parameter logic [15:0] VID_BASE = 16'h5a00, // Arbitrary value
  parameter logic [23:0] DID_BASE = 24'h3c0000 // Arbitrary value
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rst, // Async reset, high
  input wire logic [P-1:0] i_up_req, // Upload exchange wanted
  input wire logic [P-1:0] i_down_req, // Download exchange wanted
  input wire logic [P-1:0] i_swap, // Other device type fitted
  input wire logic [P-1:0] i_old, // Device below revision 1.1
  input wire logic [P-1:0] i_diff, // Device parameters changed
  input wire logic [P-1:0] i_op_wr, // Operator service write
  input wire logic [15:0] i_op_index, // Service index
  input wire logic [7:0] i_op_sub, // Service subindex
  input wire logic [7:0] i_op_val, // Service data byte
  output logic [P*16-1:0] o_vid, // Vendor id
  output logic [P*24-1:0] o_did, // Device id
  output logic [P-1:0] o_sn_ok, // Serial number matches
  output logic [P*8-1:0] o_rev, // Protocol revision
  output logic [P-1:0] o_upflag, // Upload flag
  output logic [P-1:0] o_data_diff, // Data differs
  output logic [P-1:0] o_ack // Exchange acknowledged
);
  for (genvar p = 0; p < P; p++) begin : g_dev
    logic ack_reg;
    logic flag_reg;
    int cnt;
    assign o_vid[p*16 +: 16] = i_swap[p] ? ~(VID_BASE + 16'(p)) : VID_BASE + 16'(p);
    assign o_did[p*24 +: 24] = i_swap[p] ? ~(DID_BASE + 24'(p)) : DID_BASE + 24'(p);
    assign o_sn_ok[p] = ~i_swap[p];
    assign o_rev[p*8 +: 8] = i_old[p] ? 8'h10 : REV_MIN;
    assign o_data_diff[p] = i_diff[p];
    assign o_upflag[p] = flag_reg;
    assign o_ack[p] = ack_reg;
    // Later ports answer slower, so prompt and slow exchanges both occur
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        ack_reg <= 1'b0;
        flag_reg <= 1'b0;
        cnt <= 0;
      end else begin
        ack_reg <= 1'b0;
        if (i_op_wr[p] && i_op_index == UPFLAG_INDEX && i_op_sub == 8'h00 &&
            i_op_val == UPFLAG_VALUE) begin
          flag_reg <= 1'b1;
        end
        if ((i_up_req[p] || i_down_req[p]) && !ack_reg) begin
          if (cnt == DELAY + 3 * p) begin
            ack_reg <= 1'b1;
            cnt <= 0;
            if (i_up_req[p]) begin
              flag_reg <= 1'b0;
            end
          end else begin
            cnt <= cnt + 1;
          end
        end
      end
    end
  end
endmodule : dev_model
`default_nettype wire

// file: verification/pstore_ports_test.sv
/*
  Self-checking bench for the parameter-storage block with three ports.
  Assumes the device model answers exchanges and the bench drives starts and results.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module pstore_ports_test;
  import pstore_pkg::*;
  localparam int P = 3;
  localparam logic [15:0] VB = 16'h5a00;
  localparam logic [23:0] DB = 24'h3c0000;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic [31:0] o_rdata;
  logic [P-1:0] st = '0, sw = '0, old = '0, dif = '0, opw = '0;
  logic [P-1:0] dn = '0, iw = '0, ie = '0, sn, fl, dd, ack, up, down, vf;
  logic [P*16-1:0] code = '0, vid;
  logic [P*24-1:0] did;
  logic [P*8-1:0] rev;
  logic o_irq;
  int compares = 0;
  int miscompares = 0;
  always #5 i_core_clk = ~i_core_clk;
  dev_model #(.P(P), .DELAY(2), .VID_BASE(VB), .DID_BASE(DB)) model (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_up_req(up), .i_down_req(down), .i_swap(sw), .i_old(old), .i_diff(dif),
    .i_op_wr(opw), .i_op_index(UPFLAG_INDEX), .i_op_sub(8'h00), .i_op_val(UPFLAG_VALUE),
    .o_vid(vid), .o_did(did), .o_sn_ok(sn), .o_rev(rev), .o_upflag(fl), .o_data_diff(dd),
    .o_ack(ack));
  pstore_ports #(.PORTS(P)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dev_start(st),
    .i_dev_vid(vid), .i_dev_did(did), .i_dev_sn_ok(sn), .i_dev_rev(rev), .i_dev_upflag(fl),
    .i_data_diff(dd), .i_xfer_ack(ack), .i_isdu_done(dn), .i_isdu_write(iw), .i_isdu_err(ie),
    .i_isdu_code(code), .o_up_req(up), .o_down_req(down), .o_valid_fail(vf), .o_irq(o_irq));
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, ex, o_rdata)
  endtask : rd
  task automatic start(input int p);
    @(posedge i_core_clk);
    st[p] <= 1'b1;
    @(posedge i_core_clk);
    st[p] <= 1'b0;
    #1;
  endtask : start
  task automatic wait_idle(input int p);
    for (int n = 0; n < 50 && (up[p] | down[p]) !== 1'b0; n++) begin
      @(posedge i_core_clk);
      #1;
    end
    if ((up[p] | down[p]) !== 1'b0) begin
      miscompares++;
      results();
    end
  endtask : wait_idle
  task automatic t_regs();
    logic [7:0] codes [4];
    codes = '{STORE_UP, STORE_DOWN, STORE_BOTH, STORE_NONE};
    rd(8'h00, 32'h0, "storage");
    rd(8'h04, 32'h0, "validation");
    rd(OFS_IRQ_MASK, 32'h0, "mask");
    wr(8'hc0, 32'h83);
    rd(8'hc0, 32'h0, "unmapped");
    foreach (codes[i]) begin
      wr(8'h40, {24'h0, codes[i]});
      rd(8'h40, {24'h0, codes[i]}, "code");
    end
  endtask : t_regs
  task automatic t_upload();
    wr(OFS_IRQ_MASK, 32'h1);
    wr(8'h00, {24'h0, STORE_UP});
    start(0);
    `CHK("up_req", 1'b1, up[0])
    wait_idle(0);
    @(posedge i_core_clk);
    #1;
    `CHK("irq", 1'b1, o_irq)
    rd(8'h0c, {16'h0, VB}, "vid");
    rd(8'h10, {8'h0, DB}, "did");
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge i_core_clk);
    #1;
    `CHK("irq clear", 1'b0, o_irq)
  endtask : t_upload
  task automatic t_download();
    wr(8'h00, {24'h0, STORE_BOTH});
    dif[0] <= 1'b1;
    start(0);
    `CHK("down_req", 2'b01, {up[0], down[0]})
    wait_idle(0);
    @(posedge i_core_clk);
    opw[0] <= 1'b1;
    @(posedge i_core_clk);
    opw[0] <= 1'b0;
    start(0);
    `CHK("flag up_req", 2'b10, {up[0], down[0]})
    wait_idle(0);
    dif[0] <= 1'b0;
  endtask : t_download
  task automatic t_validate();
    wr(8'h04, {24'h0, VALID_IDENT});
    sw[0] <= 1'b1;
    start(0);
    `CHK("valid_fail", 2'b10, {vf[0], up[0]})
    rd(OFS_IRQ_STAT, 32'h0000_0003, "fail flag");
    wr(8'h00, {24'h0, STORE_NONE});
    repeat (2) @(posedge i_core_clk);
    #1;
    `CHK("fail cleared", 1'b0, vf[0])
    // The new device has another serial number, so drop the identity check
    wr(8'h04, {24'h0, VALID_NONE});
    wr(8'h00, {24'h0, STORE_UP});
    start(0);
    `CHK("empty up_req", 1'b1, up[0])
    wait_idle(0);
    rd(8'h0c, {16'h0, ~VB}, "new vid");
  endtask : t_validate
  task automatic t_rev();
    wr(8'h40, {24'h0, STORE_UP});
    old[1:0] <= 2'b11;
    start(1);
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK("old rev", 1'b0, up[1])
    start(0);
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK("old rev p0", 1'b0, up[0])
    old[1:0] <= 2'b00;
    start(1);
    `CHK("rev up_req", 1'b1, up[1])
    wait_idle(1);
    rd(8'h4c, {16'h0, VB + 16'h1}, "vid p1");
    rd(8'h0c, {16'h0, ~VB}, "vid p0");
  endtask : t_rev
  task automatic t_isdu();
    wr(OFS_IRQ_STAT, 32'hffff_ffff);
    @(posedge i_core_clk);
    dn[2] <= 1'b1;
    iw[2] <= 1'b1;
    @(posedge i_core_clk);
    iw[2] <= 1'b0;
    ie[2] <= 1'b1;
    code[47:32] <= 16'h1180;
    @(posedge i_core_clk);
    ie[2] <= 1'b0;
    code[47:32] <= 16'h0;
    @(posedge i_core_clk);
    dn[2] <= 1'b0;
    rd(8'h94, {16'h0, RES_OK, REQ_READ}, "rec1");
    rd(8'h98, {16'h1180, RES_ERR, REQ_READ}, "rec2");
    rd(8'h9c, {16'h0, RES_OK, REQ_WRITE}, "rec3");
    rd(8'h14, 32'h0, "rec p0");
    rd(OFS_IRQ_STAT, 32'h0000_0c00, "irq stat");
    `CHK("masked irq", 1'b0, o_irq)
  endtask : t_isdu
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_regs();
    t_upload();
    t_download();
    t_validate();
    t_rev();
    t_isdu();
    results();
  end
endmodule : pstore_ports_test
`default_nettype wire
